/* File: src/dbgtap_pkg.sv */
package dbgtap_pkg;
  // ****************************************************************
  // tap states, binary codes
  // ****************************************************************
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
    UP_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
    EX1_IR = 4'hC, PA_IR = 4'hD, EX2_IR = 4'hE, UP_IR = 4'hF
  } dbgtap_state_e;

  // ****************************************************************
  // register map (byte offsets)
  // ****************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_TRACE_BASE = 12'h008;
  localparam logic [11:0] OFS_TRACE_LOC = 12'h00C;
  localparam logic [11:0] OFS_IDCODE = 12'h010;
  localparam logic [11:0] OFS_BSR = 12'h014;
  localparam logic [11:0] OFS_BP0 = 12'h020;
  localparam logic [11:0] OFS_WP0 = 12'h030;

  // ctrl field positions
  localparam int CTRL_TRACE_CTL = 0;
  localparam int CTRL_START_EN = 1;
  localparam int CTRL_STOP_EN = 2;
  localparam int CTRL_DEBUG_SESSION = 3;

  // reset values and fixed numbers
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TRACE_BASE_RD = 32'h0000_0000;
  localparam logic [31:0] TRACE_SRAM_BASE = 32'h1000_0000;
  localparam logic [31:0] TRACE_REG_BASE = 32'h1400_0000;
  localparam int TRACE_BYTES = 4096;
  localparam int NUM_BP = 4;
  localparam int NUM_WP = 2;
  // identification value is arbitrary
  localparam logic [31:0] IDCODE_VAL = 32'h1234_5001;
  localparam int IR_W = 4;
  localparam int BSR_W = 8;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
endpackage

/* File: src/dbgtap_sync.sv */
`timescale 1ns/1ps
module dbgtap_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic d,
  output logic q
);
  typedef struct packed {logic s1; logic s2;} dbgtap_sy_s;
  dbgtap_sy_s st_q, st_d;
  always_comb begin
    st_d = st_q;
    if (en) begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign q = st_q.s2;
endmodule // dbgtap_sync

/* File: src/dbgtap_fsm.sv */
`timescale 1ns/1ps
module dbgtap_fsm (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic force_tlr,
  input wire logic tck_rise,
  input wire logic tms,
  output dbgtap_pkg::dbgtap_state_e state
);
  typedef struct packed {dbgtap_pkg::dbgtap_state_e st;} dbgtap_fs_s;
  dbgtap_fs_s st_q, st_d;

  function automatic dbgtap_pkg::dbgtap_state_e nxt(input dbgtap_pkg::dbgtap_state_e s,
                                                    input logic m);
    case (s)
      dbgtap_pkg::TLR: nxt = m ? dbgtap_pkg::TLR : dbgtap_pkg::RTI;
      dbgtap_pkg::RTI: nxt = m ? dbgtap_pkg::SEL_DR : dbgtap_pkg::RTI;
      dbgtap_pkg::SEL_DR: nxt = m ? dbgtap_pkg::SEL_IR : dbgtap_pkg::CAP_DR;
      dbgtap_pkg::CAP_DR: nxt = m ? dbgtap_pkg::EX1_DR : dbgtap_pkg::SH_DR;
      dbgtap_pkg::SH_DR: nxt = m ? dbgtap_pkg::EX1_DR : dbgtap_pkg::SH_DR;
      dbgtap_pkg::EX1_DR: nxt = m ? dbgtap_pkg::UP_DR : dbgtap_pkg::PA_DR;
      dbgtap_pkg::PA_DR: nxt = m ? dbgtap_pkg::EX2_DR : dbgtap_pkg::PA_DR;
      dbgtap_pkg::EX2_DR: nxt = m ? dbgtap_pkg::UP_DR : dbgtap_pkg::SH_DR;
      dbgtap_pkg::UP_DR: nxt = m ? dbgtap_pkg::SEL_DR : dbgtap_pkg::RTI;
      dbgtap_pkg::SEL_IR: nxt = m ? dbgtap_pkg::TLR : dbgtap_pkg::CAP_IR;
      dbgtap_pkg::CAP_IR: nxt = m ? dbgtap_pkg::EX1_IR : dbgtap_pkg::SH_IR;
      dbgtap_pkg::SH_IR: nxt = m ? dbgtap_pkg::EX1_IR : dbgtap_pkg::SH_IR;
      dbgtap_pkg::EX1_IR: nxt = m ? dbgtap_pkg::UP_IR : dbgtap_pkg::PA_IR;
      dbgtap_pkg::PA_IR: nxt = m ? dbgtap_pkg::EX2_IR : dbgtap_pkg::PA_IR;
      dbgtap_pkg::EX2_IR: nxt = m ? dbgtap_pkg::UP_IR : dbgtap_pkg::SH_IR;
      dbgtap_pkg::UP_IR: nxt = m ? dbgtap_pkg::SEL_DR : dbgtap_pkg::RTI;
      default: nxt = dbgtap_pkg::TLR;
    endcase
  endfunction

  always_comb begin
    st_d = st_q;
    if (en) begin
      if (force_tlr) begin
        st_d.st = dbgtap_pkg::TLR;
      end else if (tck_rise) begin
        st_d.st = nxt(st_q.st, tms);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{st: dbgtap_pkg::TLR};
    end else begin
      st_q <= st_d;
    end
  end
  assign state = st_q.st;

  tlr_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en && force_tlr) |=> (state == dbgtap_pkg::TLR))
    else $error("tap not in reset state after force");
  rti_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en && !force_tlr && tck_rise && !tms && state == dbgtap_pkg::RTI)
    |=> (state == dbgtap_pkg::RTI))
    else $error("tap left idle with tms low");
  tms_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en && !force_tlr && tck_rise && tms && state == dbgtap_pkg::SEL_DR)
    |=> (state == dbgtap_pkg::SEL_IR))
    else $error("tms did not steer select state");
  tap_still_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!tck_rise && !force_tlr) |=> $stable(state))
    else $error("tap moved without tck edge");
endmodule // dbgtap_fsm

/* File: src/dbgtap_top.sv */
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - reset pin low: scan, high: wire debug
// - wire debug off while chip in reset
// - tdo changes on falling tck
// - por, brownout, trst low force reset state
// - first tck with reset high: idle
// - sampled tms picks next tap state
// - trst resets; tdi shifts into register
// - halted core freezes only system tick; code stops systick only while the ctrl debug session bit is set
// - four breakpoints, two watchpoints as triggers
// - trace only in first sram bank, 4 KB
// - trace run from control and enables
// - trace registers based at fixed address
// - trace base register reads zero
// - scan port gives no core access
// - wire debug pins enabled after reset
// - scan pins selected by hardware only
module dbgtap_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin,
  input wire logic por_event,
  input wire logic brownout_reset_event,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  output logic swd_enable,
  input wire logic core_halted,
  output logic systick_run,
  input wire logic [31:0] core_pc,
  input wire logic [31:0] core_daddr,
  output logic [3:0] bp_hit,
  output logic [1:0] wp_trigger,
  output logic trace_active,
  output logic [31:0] trace_waddr
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic tck_old;
    logic [31:0] ctrl;
    logic [31:0] trace_loc;
    logic [dbgtap_pkg::NUM_BP-1:0][31:0] bp;
    logic [dbgtap_pkg::NUM_WP-1:0][31:0] wp;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [31:0] dr_sh;
    logic [7:0] bsr;
    logic tdo;
    logic tdo_oe;
    logic [31:0] prdata;
    logic trace_on;
  } dbgtap_top_s;
  dbgtap_top_s st_q, st_d;

  logic rst_pin_s, tck_s, tms_s, tdi_s, trst_n_s;
  logic tck_rise, tck_fall, force_tlr;
  dbgtap_pkg::dbgtap_state_e tap;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] sy_in, sy_out;
  assign sy_in = {reset_pin, tck, tms, tdi, trst_n};
  assign {rst_pin_s, tck_s, tms_s, tdi_s, trst_n_s} = sy_out;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      dbgtap_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .en(clk_en),
        .d(sy_in[gi]),
        .q(sy_out[gi])
      );
    end
  endgenerate

  assign tck_rise = tck_s && !st_q.tck_old;
  assign tck_fall = !tck_s && st_q.tck_old;
  assign force_tlr = por_event || brownout_reset_event || !trst_n_s;

  dbgtap_fsm u_fsm (
    .pclk(pclk),
    .presetn(presetn),
    .en(clk_en),
    .force_tlr(force_tlr),
    .tck_rise(tck_rise),
    .tms(rst_pin_s ? 1'b0 : tms_s),
    .state(tap)
  );

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d.tck_old = tck_s;
      if (tck_rise && !rst_pin_s) begin
        case (tap)
          dbgtap_pkg::CAP_IR: st_d.ir_sh = 4'h1;
          dbgtap_pkg::SH_IR: st_d.ir_sh = {tdi_s, st_q.ir_sh[3:1]};
          dbgtap_pkg::UP_IR: st_d.ir = st_q.ir_sh;
          dbgtap_pkg::CAP_DR: begin
            if (st_q.ir == dbgtap_pkg::IR_IDCODE) begin
              st_d.dr_sh = dbgtap_pkg::IDCODE_VAL;
            end else begin
              st_d.dr_sh = {24'h000000, st_q.bsr};
            end
          end
          dbgtap_pkg::SH_DR: begin
            if (st_q.ir == dbgtap_pkg::IR_BYPASS) begin
              st_d.dr_sh = {31'h00000000, tdi_s};
            end else begin
              st_d.dr_sh = {tdi_s, st_q.dr_sh[31:1]};
            end
          end
          dbgtap_pkg::UP_DR: begin
            if (st_q.ir == dbgtap_pkg::IR_SAMPLE) begin
              st_d.bsr = st_q.dr_sh[31:24];
            end
          end
          default: st_d.dr_sh = st_q.dr_sh;
        endcase
      end
      if (tap == dbgtap_pkg::TLR) begin
        st_d.ir = dbgtap_pkg::IR_IDCODE;
      end
      if (tck_fall) begin
        st_d.tdo_oe = !rst_pin_s && (tap == dbgtap_pkg::SH_DR || tap == dbgtap_pkg::SH_IR);
        st_d.tdo = (tap == dbgtap_pkg::SH_IR) ? st_q.ir_sh[0] : st_q.dr_sh[0];
      end
      if (rst_pin_s) begin
        st_d.tdo_oe = 1'b0;
      end
      // apb read data staged in setup phase
      if (psel && !penable && !pwrite) begin
        st_d.prdata = 32'h0000_0000;
        if (hit(paddr, dbgtap_pkg::OFS_CTRL)) st_d.prdata = st_q.ctrl;
        if (hit(paddr, dbgtap_pkg::OFS_STAT)) st_d.prdata = {26'h0, st_q.trace_on, rst_pin_s, tap};
        if (hit(paddr, dbgtap_pkg::OFS_TRACE_BASE)) st_d.prdata = dbgtap_pkg::TRACE_BASE_RD;
        if (hit(paddr, dbgtap_pkg::OFS_TRACE_LOC)) st_d.prdata = st_q.trace_loc;
        if (hit(paddr, dbgtap_pkg::OFS_IDCODE)) st_d.prdata = dbgtap_pkg::IDCODE_VAL;
        if (hit(paddr, dbgtap_pkg::OFS_BSR)) st_d.prdata = {24'h000000, st_q.bsr};
        for (int i = 0; i < dbgtap_pkg::NUM_BP; i++) begin
          if (hit(paddr, dbgtap_pkg::OFS_BP0 + 12'(4 * i))) st_d.prdata = st_q.bp[i];
        end
        for (int i = 0; i < dbgtap_pkg::NUM_WP; i++) begin
          if (hit(paddr, dbgtap_pkg::OFS_WP0 + 12'(4 * i))) st_d.prdata = st_q.wp[i];
        end
      end
      // apb write in access phase
      if (psel && penable && pwrite) begin
        if (hit(paddr, dbgtap_pkg::OFS_CTRL)) st_d.ctrl = {28'h0000000, pwdata[3:0]};
        if (hit(paddr, dbgtap_pkg::OFS_TRACE_LOC)) st_d.trace_loc = {20'h00000, pwdata[11:2], 2'b00};
        for (int i = 0; i < dbgtap_pkg::NUM_BP; i++) begin
          if (hit(paddr, dbgtap_pkg::OFS_BP0 + 12'(4 * i))) st_d.bp[i] = pwdata;
        end
        for (int i = 0; i < dbgtap_pkg::NUM_WP; i++) begin
          if (hit(paddr, dbgtap_pkg::OFS_WP0 + 12'(4 * i))) st_d.wp[i] = pwdata;
        end
      end
      if (st_q.ctrl[dbgtap_pkg::CTRL_TRACE_CTL] && st_q.ctrl[dbgtap_pkg::CTRL_START_EN]) begin
        st_d.trace_on = 1'b1;
      end else if (!st_q.ctrl[dbgtap_pkg::CTRL_TRACE_CTL]
                   && st_q.ctrl[dbgtap_pkg::CTRL_STOP_EN]) begin
        st_d.trace_on = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic unmapped;
  always_comb begin
    unmapped = 1'b1;
    if (hit(paddr, dbgtap_pkg::OFS_CTRL) || hit(paddr, dbgtap_pkg::OFS_STAT)
        || hit(paddr, dbgtap_pkg::OFS_TRACE_BASE) || hit(paddr, dbgtap_pkg::OFS_TRACE_LOC)
        || hit(paddr, dbgtap_pkg::OFS_IDCODE) || hit(paddr, dbgtap_pkg::OFS_BSR)) begin
      unmapped = 1'b0;
    end
    for (int i = 0; i < dbgtap_pkg::NUM_BP; i++) begin
      if (hit(paddr, dbgtap_pkg::OFS_BP0 + 12'(4 * i))) unmapped = 1'b0;
    end
    for (int i = 0; i < dbgtap_pkg::NUM_WP; i++) begin
      if (hit(paddr, dbgtap_pkg::OFS_WP0 + 12'(4 * i))) unmapped = 1'b0;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped;
  assign prdata = st_q.prdata;

  assign swd_enable = rst_pin_s && presetn;
  assign tdo = st_q.tdo;
  assign tdo_oe = st_q.tdo_oe;
  assign systick_run = !(st_q.ctrl[dbgtap_pkg::CTRL_DEBUG_SESSION] && core_halted);

  generate
    for (gi = 0; gi < dbgtap_pkg::NUM_BP; gi++) begin : g_bp
      assign bp_hit[gi] = swd_enable && st_q.bp[gi][0] && (core_pc[31:1] == st_q.bp[gi][31:1]);
    end
    for (gi = 0; gi < dbgtap_pkg::NUM_WP; gi++) begin : g_wp
      assign wp_trigger[gi] = st_q.wp[gi][0] && (core_daddr[31:2] == st_q.wp[gi][31:2]);
    end
  endgenerate

  assign trace_active = st_q.trace_on;
  assign trace_waddr = dbgtap_pkg::TRACE_SRAM_BASE + {20'h00000, st_q.trace_loc[11:0]};

  swd_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rst_pin_s |-> !swd_enable)
    else $error("wire debug enabled while reset pin low");
  tdo_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !$past(tck_fall) && !rst_pin_s && $past(!rst_pin_s)) |-> $stable(tdo))
    else $error("tdo changed away from falling tck");
  first_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && rst_pin_s && tck_rise && !force_tlr && tap == dbgtap_pkg::TLR)
    |=> tap == dbgtap_pkg::RTI)
    else $error("tap did not reach idle on first tck");
  tick_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (core_halted && st_q.ctrl[dbgtap_pkg::CTRL_DEBUG_SESSION]) |-> !systick_run)
    else $error("systick ran while halted");
  base_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && $past(clk_en) && psel && penable && !pwrite
     && paddr == dbgtap_pkg::OFS_TRACE_BASE) |-> prdata == 32'h0000_0000)
    else $error("trace base read not zero");
  trace_go_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && st_q.ctrl[dbgtap_pkg::CTRL_TRACE_CTL] && st_q.ctrl[dbgtap_pkg::CTRL_START_EN])
    |=> trace_active)
    else $error("trace did not start");
  tdo_scan_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_pin_s ##1 rst_pin_s |-> !tdo_oe)
    else $error("tdo driven during wire debug");
  trace_bank_a: assert property (@(posedge pclk) disable iff (!presetn)
    trace_waddr[31:12] == 20'h10000)
    else $error("trace address outside first bank");
  bp_scan_a: assert property (@(posedge pclk) disable iff (!presetn)
    !swd_enable |-> bp_hit == 4'h0)
    else $error("breakpoint matched outside wire debug");
  ir_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && tap == dbgtap_pkg::TLR) |=> st_q.ir == dbgtap_pkg::IR_IDCODE)
    else $error("instruction not reset in reset state");
  tick_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    !core_halted |-> systick_run)
    else $error("systick stopped while core running");
endmodule // dbgtap_top

/* File: verification/dbgtap_tester.sv */
`timescale 1ns/1ps
// ****************
// boundary-scan tester model
// ****************
module dbgtap_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  output logic reset_pin,
  input wire logic tdo
);
  // no sleep entry, loader entry pin never held low
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b1;
    reset_pin = 1'b1;
  end

  task automatic step(input logic m, input logic i, output logic o);
    tms = m;
    tdi = i;
    #200;
    o = tdo;
    tck = 1'b1;
    #200;
    tck = 1'b0;
  endtask

  task automatic walk(input logic [7:0] seq, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      step(seq[i], 1'b1, o);
    end
  endtask

  // shift lsb first, leave on last bit
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
  endtask

  // power up high, wait, pull low
  task automatic enter_scan;
    reset_pin = 1'b1;
    #250000;
    reset_pin = 1'b0;
  endtask

  task automatic leave_scan;
    trst_n = 1'b0;
    #2000;
    reset_pin = 1'b1;
    #2000;
    trst_n = 1'b1;
  endtask
endmodule // dbgtap_tester

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic e;
  } dbgtap_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic por_event = 1'b0;
  logic brownout_reset_event = 1'b0;
  logic core_halted = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] core_pc = 32'h0;
  logic [31:0] core_daddr = 32'h0;
  logic [31:0] prdata, trace_waddr, rd, sh;
  logic pready, pslverr, tdo, tdo_oe, swd_enable, systick_run, trace_active, er;
  logic tck, tms, tdi, trst_n, reset_pin;
  logic [3:0] bp_hit;
  logic [1:0] wp_trigger;
  int fail_count = 0;
  int samples_checked = 0;
  dbgtap_row_s rows [7] = '{
    '{1'b1, dbgtap_pkg::OFS_TRACE_BASE, 32'hFFFF_FFFF, dbgtap_pkg::TRACE_BASE_RD, 1'b0},
    '{1'b1, dbgtap_pkg::OFS_TRACE_LOC, 32'h0000_0FFC, 32'h0000_0FFC, 1'b0},
    '{1'b1, dbgtap_pkg::OFS_BP0, 32'h0000_0201, 32'h0000_0201, 1'b0},
    '{1'b1, 12'h02C, 32'h0000_0401, 32'h0000_0401, 1'b0},
    '{1'b1, 12'h034, 32'h0000_0301, 32'h0000_0301, 1'b0},
    '{1'b1, 12'h0FC, 32'h1234_5678, 32'h0000_0000, 1'b1},
    '{1'b0, dbgtap_pkg::OFS_IDCODE, 32'h0, dbgtap_pkg::IDCODE_VAL, 1'b0}
  };

  always #25 pclk = ~pclk;

  dbgtap_top uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_pin(reset_pin), .por_event(por_event),
    .brownout_reset_event(brownout_reset_event), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .swd_enable(swd_enable),
    .core_halted(core_halted), .systick_run(systick_run), .core_pc(core_pc),
    .core_daddr(core_daddr), .bp_hit(bp_hit), .wp_trigger(wp_trigger),
    .trace_active(trace_active), .trace_waddr(trace_waddr));

  dbgtap_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .reset_pin(reset_pin), .tdo(tdo));

  // ****************
  // checks and bus cycles
  // ****************
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) fail_count++;
    er = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    #1;
  endtask

  task automatic tap_is(input dbgtap_pkg::dbgtap_state_e s);
    apb(1'b0, dbgtap_pkg::OFS_STAT, 32'h0);
    chk_word("tap_state", {28'h0, s}, {28'h0, rd[3:0]});
  endtask

  task automatic settle;
    repeat (4) @(posedge pclk);
    #1;
  endtask

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    fail_count++;
    stop_test();
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (6) @(posedge pclk);
    #1;
    chk_bit("swd_in_reset", 1'b0, swd_enable);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk_bit("swd_after_reset", 1'b1, swd_enable);
    chk_bit("systick_reset", 1'b1, systick_run);
    apb(1'b0, dbgtap_pkg::OFS_CTRL, 32'h0);
    chk_word("ctrl_reset", dbgtap_pkg::CTRL_RST, rd);
    done("reset");
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk_word("reg_read", rows[i].r, rd);
      chk_bit("reg_err", rows[i].e, er);
    end
    done("registers");
    @(posedge pclk);
    core_pc <= 32'h0000_0200;
    core_daddr <= 32'h0000_0300;
    settle();
    chk_word("bp_hit", 32'h1, {28'h0, bp_hit});
    chk_word("wp_trig", 32'h2, {30'h0, wp_trigger});
    @(posedge pclk);
    core_pc <= 32'h0000_0400;
    settle();
    chk_word("bp_hit3", 32'h8, {28'h0, bp_hit});
    done("match");
    @(posedge pclk);
    core_halted <= 1'b1;
    settle();
    chk_bit("systick_no_session", 1'b1, systick_run);
    apb(1'b1, dbgtap_pkg::OFS_CTRL, 32'h8);
    chk_bit("systick_halted", 1'b0, systick_run);
    @(posedge pclk);
    core_halted <= 1'b0;
    settle();
    chk_bit("systick_running", 1'b1, systick_run);
    done("systick");
    apb(1'b1, dbgtap_pkg::OFS_CTRL, 32'h1);
    chk_bit("trace_no_start_en", 1'b0, trace_active);
    apb(1'b1, dbgtap_pkg::OFS_CTRL, 32'h3);
    chk_bit("trace_start", 1'b1, trace_active);
    chk_word("trace_addr", dbgtap_pkg::TRACE_SRAM_BASE + 32'hFFC, trace_waddr);
    apb(1'b1, dbgtap_pkg::OFS_CTRL, 32'h1);
    chk_bit("trace_no_stop_en", 1'b1, trace_active);
    apb(1'b1, dbgtap_pkg::OFS_CTRL, 32'h4);
    chk_bit("trace_stop", 1'b0, trace_active);
    done("trace");
    tester.enter_scan();
    settle();
    chk_bit("swd_in_scan", 1'b0, swd_enable);
    tester.walk(8'h1F, 6);
    tap_is(dbgtap_pkg::RTI);
    tester.walk(8'h01, 3);
    tester.shift(32, 32'h0, sh);
    chk_word("idcode", dbgtap_pkg::IDCODE_VAL, sh);
    tester.walk(8'h01, 2);
    tester.walk(8'h03, 4);
    tester.shift(dbgtap_pkg::IR_W, {28'h0, dbgtap_pkg::IR_BYPASS}, sh);
    chk_word("ir_capture", 32'h1, sh);
    tester.walk(8'h01, 2);
    tester.walk(8'h01, 3);
    tester.shift(4, 32'h5, sh);
    chk_word("bypass", 32'hA, sh);
    tester.walk(8'h00, 1);
    tap_is(dbgtap_pkg::PA_DR);
    tester.leave_scan();
    settle();
    tap_is(dbgtap_pkg::TLR);
    chk_bit("swd_back", 1'b1, swd_enable);
    tester.walk(8'h00, 1);
    tap_is(dbgtap_pkg::RTI);
    done("scan");
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      if (k == 0) por_event <= 1'b1;
      else brownout_reset_event <= 1'b1;
      @(posedge pclk);
      por_event <= 1'b0;
      brownout_reset_event <= 1'b0;
      settle();
      tap_is(dbgtap_pkg::TLR);
      tester.walk(8'h00, 1);
      tap_is(dbgtap_pkg::RTI);
    end
    done("tap_reset");
    @(posedge pclk);
    clk_en <= 1'b0;
    por_event <= 1'b1;
    @(posedge pclk);
    por_event <= 1'b0;
    settle();
    @(posedge pclk);
    clk_en <= 1'b1;
    tap_is(dbgtap_pkg::RTI);
    done("freeze");
    stop_test();
  end
endmodule // tb_top
